//--- hdl/modbus_bit_read_responder.sv
// Purpose: server and client handling of read-coils and read-discrete-inputs PDUs
// Assumes: PDU bytes arrive framed, with a last marker on the final byte
// Notes: server replies one request at a time; client side never stalls
`timescale 1ns/10ps

// Overview of operation
// - read coils accepted only for starting address 0 to 15, address n is output n
// - read coils quantity accepted from one to sixteen
// - coil reply echoes function one then byte count, quantity over eight rounded up
// - status bytes follow, bit zero of first byte is the starting output
// - bits beyond the requested quantity in the last byte read zero
// - read inputs accepted only for starting address 0 to 15, address n is input n
// - read inputs quantity accepted from one to sixteen
// - input reply echoes function two then byte count, quantity over eight rounded up
// - input status packed one bit each, starting input in bit zero
// - reported input bit is zero when active, one when inactive
// - client records function code of last response, top bit set on exception
// - client keeps the exception code of an exception reply for read-back
// - client stores returned status bytes into consecutive array elements
// - invalid request answered with code plus 0x80 and exception one or two
module modbus_bit_read_responder (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // live bank state
    input wire logic [15:0] digitalOutputs,
    input wire logic [15:0] digitalInputs,
    // server request stream
    input wire logic reqValid,
    input wire logic [7:0] reqByte,
    input wire logic reqLast,
    output logic reqReady,
    // server reply stream
    output logic rspValid,
    output logic [7:0] rspByte,
    output logic rspLast,
    input wire logic rspReady,
    // client response stream
    input wire logic cliValid,
    input wire logic [7:0] cliByte,
    input wire logic cliLast,
    // client results
    output logic [7:0] lastResponseFunction,
    output logic [7:0] lastExceptionCode,
    output logic arrWrite,
    output logic [7:0] arrIndex,
    output logic [7:0] arrData
);
    typedef struct packed {
        bit_read_pkg::srv_state_type srv;
        logic [4:0][7:0] req;
        logic [2:0] reqCount;
        logic reqOver;
        logic [3:0][7:0] reply;
        logic [1:0] replyIdx;
        logic [1:0] replyLen;
        logic [7:0] rspByte;
        bit_read_pkg::cli_state_type cli;
        logic [7:0] lastFunc;
        logic [7:0] lastExc;
        logic [7:0] remaining;
        logic [7:0] elemIdx;
        logic arrWrite;
        logic [7:0] arrIndex;
        logic [7:0] arrData;
    } state_type;

    state_type s_q;
    state_type s_d;

    status_pack_if pk ();

    status_packer u_packer (
        .pk(pk)
    );

    // decoded request fields, valid while deciding
    logic [7:0] reqFunc;
    logic [15:0] reqAddr;
    logic [15:0] reqQty;
    logic [16:0] reqEnd;
    logic funcKnown;
    logic addrOk;
    logic qtyOk;
    logic spanOk;
    logic frameOk;
    logic [1:0] byteCount;
    logic reqFull;
    logic windowOk;
    logic reqRejected;
    logic [7:0] reqExcCode;
    logic [7:0] replyHead;

    // transfer events and reply position, shared by the state machine and the port view
    logic reqTake;
    logic rspTake;
    logic replyDone;
    logic [1:0] nextIdx;
    logic cliDataLast;

    assign reqFunc = s_q.req[bit_read_pkg::IDX_FUNC];
    assign reqAddr = {s_q.req[bit_read_pkg::IDX_ADDR_HI], s_q.req[bit_read_pkg::IDX_ADDR_LO]};
    assign reqQty = {s_q.req[bit_read_pkg::IDX_QTY_HI], s_q.req[bit_read_pkg::IDX_QTY_LO]};
    assign reqEnd = {1'b0, reqAddr} + {1'b0, reqQty};

    // request checks; the same limits serve both banks
    assign funcKnown = (reqFunc == bit_read_pkg::FUNC_READ_COILS) ||
                       (reqFunc == bit_read_pkg::FUNC_READ_INPUTS);
    // a frame counts only with exactly five bytes; extra bytes spoil it
    assign reqFull = (s_q.reqCount == bit_read_pkg::REQ_LEN);
    assign frameOk = reqFull && !s_q.reqOver;
    assign addrOk = ({1'b0, reqAddr} < bit_read_pkg::BANK_LIMIT);
    assign qtyOk = (reqQty >= bit_read_pkg::QTY_MIN) &&
                   ({1'b0, reqQty} <= bit_read_pkg::BANK_LIMIT);
    assign spanOk = (reqEnd <= bit_read_pkg::BANK_LIMIT);
    // quantity over eight, rounded up: one or two bytes
    assign byteCount = (reqQty[4:0] <= bit_read_pkg::QTY_ONE_BYTE) ? 2'h1 : 2'h2;

    // verdict on the stored request; an unknown code outranks a bad window
    assign windowOk = frameOk && addrOk && qtyOk && spanOk;
    assign reqRejected = !(funcKnown && windowOk);
    assign reqExcCode = funcKnown ? bit_read_pkg::EXC_ILLEGAL_ADDRESS
                                  : bit_read_pkg::EXC_ILLEGAL_FUNCTION;
    // exception replies return the request code with the flag bit set
    assign replyHead = reqRejected ? (reqFunc | bit_read_pkg::EXCEPTION_FLAG) : reqFunc;

    // packer sees the stored request and the live banks
    assign pk.fromInputs = (reqFunc == bit_read_pkg::FUNC_READ_INPUTS);
    assign pk.start = reqAddr[3:0];
    assign pk.qty = reqQty[4:0];
    assign pk.outputsState = digitalOutputs;
    assign pk.inputsState = digitalInputs;

    // handshakes are combinational, data comes from flops
    assign reqReady = (s_q.srv == bit_read_pkg::SRV_COLLECT);
    assign rspValid = (s_q.srv == bit_read_pkg::SRV_REPLY);
    assign rspLast = rspValid && replyDone;

    // transfer events; the reply index stops at its length, so its wrap never shows
    assign reqTake = reqValid && reqReady;
    assign rspTake = rspValid && rspReady;
    assign replyDone = (s_q.replyIdx == s_q.replyLen);
    assign nextIdx = s_q.replyIdx + 2'h1;
    // the data byte that empties the count closes the stored block
    assign cliDataLast = (s_q.remaining == 8'h01);
    assign rspByte = s_q.rspByte;
    assign lastResponseFunction = s_q.lastFunc;
    assign lastExceptionCode = s_q.lastExc;
    assign arrWrite = s_q.arrWrite;
    assign arrIndex = s_q.arrIndex;
    assign arrData = s_q.arrData;

    // next-state logic for both the server and the client halves
    always_comb begin
        s_d = s_q;
        s_d.arrWrite = 1'b0;

        // server side
        unique case (s_q.srv)
            // gather up to five request bytes
            bit_read_pkg::SRV_COLLECT: begin
                if (reqTake) begin
                    // bytes past the fifth are taken and dropped, but mark the frame as too long
                    if (!reqFull) begin
                        s_d.req[s_q.reqCount] = reqByte;
                        s_d.reqCount = s_q.reqCount + 3'h1;
                    end else begin
                        s_d.reqOver = 1'b1;
                    end
                    if (reqLast) begin
                        s_d.srv = bit_read_pkg::SRV_DECIDE;
                    end
                end
            end

            // one cycle to judge the request and load the whole reply
            bit_read_pkg::SRV_DECIDE: begin
                s_d.replyIdx = 2'h0;
                s_d.reply[0] = replyHead;
                if (reqRejected) begin
                    // flagged code then a single exception byte; no stale status is kept
                    s_d.reply[1] = reqExcCode;
                    s_d.reply[2] = bit_read_pkg::BYTE_RESET;
                    s_d.reply[3] = bit_read_pkg::BYTE_RESET;
                    s_d.replyLen = 2'h1;
                end else begin
                    // byte count, then one or two status bytes
                    s_d.reply[1] = {6'h00, byteCount};
                    s_d.reply[2] = pk.status[7:0];
                    s_d.reply[3] = pk.status[15:8];
                    s_d.replyLen = byteCount + 2'h1;
                end
                s_d.rspByte = replyHead;
                s_d.srv = bit_read_pkg::SRV_REPLY;
            end

            // hand out reply bytes as the consumer takes them
            bit_read_pkg::SRV_REPLY: begin
                if (rspTake) begin
                    if (replyDone) begin
                        // reply finished: forget the old request before collecting anew
                        s_d.srv = bit_read_pkg::SRV_COLLECT;
                        s_d.reqCount = 3'h0;
                        s_d.reqOver = 1'b0;
                        s_d.req = '0;
                    end else begin
                        s_d.replyIdx = nextIdx;
                        s_d.rspByte = s_q.reply[nextIdx];
                    end
                end
            end

            default: begin
                s_d.srv = bit_read_pkg::SRV_COLLECT;
            end
        endcase

        // client side; a last marker always re-arms for the next response
        if (cliValid) begin
            unique case (s_q.cli)
                // first byte: the function code, top bit marks an exception
                bit_read_pkg::CLI_FUNC: begin
                    s_d.lastFunc = cliByte;
                    s_d.elemIdx = 8'h00;
                    if (cliByte[7]) begin
                        s_d.cli = bit_read_pkg::CLI_EXC;
                    end else begin
                        s_d.cli = bit_read_pkg::CLI_COUNT;
                    end
                end

                // exception code stays until the next exception replaces it
                bit_read_pkg::CLI_EXC: begin
                    s_d.lastExc = cliByte;
                    s_d.cli = bit_read_pkg::CLI_SKIP;
                end

                // byte count; zero leaves nothing to store
                bit_read_pkg::CLI_COUNT: begin
                    s_d.remaining = cliByte;
                    if (cliByte == 8'h00) begin
                        s_d.cli = bit_read_pkg::CLI_SKIP;
                    end else begin
                        s_d.cli = bit_read_pkg::CLI_DATA;
                    end
                end

                bit_read_pkg::CLI_DATA: begin
                    // one status byte per array element, in arrival order
                    s_d.arrWrite = 1'b1;
                    s_d.arrIndex = s_q.elemIdx;
                    s_d.arrData = cliByte;
                    s_d.elemIdx = s_q.elemIdx + 8'h01;
                    s_d.remaining = s_q.remaining - 8'h01;
                    if (cliDataLast) begin
                        s_d.cli = bit_read_pkg::CLI_SKIP;
                    end
                end

                // bytes past the count are ignored until the last marker
                bit_read_pkg::CLI_SKIP: begin
                    s_d.cli = bit_read_pkg::CLI_SKIP;
                end
                default: begin
                    s_d.cli = bit_read_pkg::CLI_FUNC;
                end
            endcase
            if (cliLast) begin
                s_d.cli = bit_read_pkg::CLI_FUNC;
            end
        end
    end

    // one register for all state; synchronous reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            // server half
            s_q.srv <= bit_read_pkg::SRV_COLLECT;
            s_q.req <= '0;
            s_q.reqCount <= 3'h0;
            s_q.reqOver <= 1'b0;
            s_q.reply <= '0;
            s_q.replyIdx <= 2'h0;
            s_q.replyLen <= 2'h0;
            s_q.rspByte <= bit_read_pkg::BYTE_RESET;
            // client half
            s_q.cli <= bit_read_pkg::CLI_FUNC;
            s_q.lastFunc <= bit_read_pkg::BYTE_RESET;
            s_q.lastExc <= bit_read_pkg::BYTE_RESET;
            s_q.remaining <= 8'h00;
            s_q.elemIdx <= 8'h00;
            s_q.arrWrite <= 1'b0;
            s_q.arrIndex <= 8'h00;
            s_q.arrData <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : modbus_bit_read_responder

//--- hdl/bit_read_pkg.sv
// Purpose: shared constants and types of the bit-read responder
// Assumes: byte-wide protocol data units, framing done outside
// Notes: function and exception codes follow the bus protocol
package bit_read_pkg;
    // function codes handled here
    localparam logic [7:0] FUNC_READ_COILS = 8'h01;
    localparam logic [7:0] FUNC_READ_INPUTS = 8'h02;
    // exception reply marking and codes
    localparam logic [7:0] EXCEPTION_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
    // bank geometry and request layout
    localparam int BANK_BITS = 16;
    localparam logic [16:0] BANK_LIMIT = 17'h00010;
    localparam logic [15:0] QTY_MIN = 16'h0001;
    localparam logic [4:0] QTY_ONE_BYTE = 5'h08;
    localparam logic [2:0] REQ_LEN = 3'h5;
    localparam logic [2:0] IDX_FUNC = 3'h0;
    localparam logic [2:0] IDX_ADDR_HI = 3'h1;
    localparam logic [2:0] IDX_ADDR_LO = 3'h2;
    localparam logic [2:0] IDX_QTY_HI = 3'h3;
    localparam logic [2:0] IDX_QTY_LO = 3'h4;
    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        SRV_COLLECT = 2'b00,
        SRV_DECIDE = 2'b01,
        SRV_REPLY = 2'b10
    } srv_state_type;

    typedef enum logic [2:0] {
        CLI_FUNC = 3'b000,
        CLI_EXC = 3'b001,
        CLI_COUNT = 3'b010,
        CLI_DATA = 3'b011,
        CLI_SKIP = 3'b100
    } cli_state_type;
endpackage : bit_read_pkg

//--- hdl/status_pack_if.sv
// Purpose: carries a bit-window selection to the status packer and the packed word back
// Assumes: start and quantity already validated by the requester
// Notes: fromInputs picks the input bank, otherwise the output bank
`timescale 1ns/10ps
interface status_pack_if;
    logic fromInputs;
    logic [3:0] start;
    logic [4:0] qty;
    logic [15:0] outputsState;
    logic [15:0] inputsState;
    logic [15:0] status;

    modport requester (
        output fromInputs,
        output start,
        output qty,
        output outputsState,
        output inputsState,
        input status
    );

    modport packer (
        input fromInputs,
        input start,
        input qty,
        input outputsState,
        input inputsState,
        output status
    );
endinterface : status_pack_if

//--- hdl/status_packer.sv
// Purpose: packs a window of outputs or inputs into a status word, LSB first
// Assumes: start plus qty never exceeds the bank width
// Notes: purely combinational
`timescale 1ns/10ps
module status_packer (
    // selection and packed result
    status_pack_if.packer pk
);
    logic [15:0] bank;
    logic [15:0] shifted;

    // inputs report inverted: active reads zero
    assign bank = pk.fromInputs ? ~pk.inputsState : pk.outputsState;
    // requested start lands in bit zero of the first byte
    assign shifted = bank >> pk.start;

    // bits past the quantity are forced to zero, never real state
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_mask
            assign pk.status[i] = (5'(i) < pk.qty) ? shifted[i] : 1'b0;
        end
    endgenerate
endmodule : status_packer

//--- bench/modbus_bit_read_responder_sva.sv
// Purpose: temporal checks on the bit-read responder ports
// Assumes: one clock, synchronous active-high reset
// Notes: helper flags mark the head byte of each reply and response
`timescale 1ns/10ps
module modbus_bit_read_responder_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // server streams
    input wire logic reqValid,
    input wire logic reqLast,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic [7:0] rspByte,
    input wire logic rspLast,
    input wire logic rspReady,
    // client stream and results
    input wire logic cliValid,
    input wire logic [7:0] cliByte,
    input wire logic cliLast,
    input wire logic [7:0] lastResponseFunction,
    input wire logic [7:0] lastExceptionCode,
    input wire logic arrWrite,
    input wire logic [7:0] arrIndex
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic headRsp_q;
    logic headCli_q;
    // head flags, so byte positions need no full decoder here
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            headRsp_q <= 1'b0;
            headCli_q <= 1'b1;
        end else begin
            if (reqValid && reqReady && reqLast) headRsp_q <= 1'b1;
            else if (rspValid && rspReady) headRsp_q <= 1'b0;
            if (cliValid) headCli_q <= cliLast;
        end
    end
    sequence normHead;
        headRsp_q && rspValid && rspReady && !rspByte[7];
    endsequence
    sequence excHead;
        headRsp_q && rspValid && rspReady && rspByte[7];
    endsequence
    AST_REPLY_DELAY: assert property (reqValid && reqReady && reqLast |=> !reqReady ##1 rspValid)
        else $error("reply did not start two cycles after request end");
    AST_REPLY_HOLD: assert property (rspValid && !rspReady |=> rspValid && $stable(rspByte) && $stable(rspLast))
        else $error("reply byte changed while stalled");
    AST_NO_REQ_IN_REPLY: assert property (rspValid |-> !reqReady)
        else $error("request accepted during reply");
    AST_COUNT_BYTE: assert property (normHead |=> rspValid && !rspLast && rspByte inside {8'h01, 8'h02})
        else $error("byte count not one or two");
    AST_EXC_BODY: assert property (excHead |=> rspValid && rspLast && rspByte inside {8'h01, 8'h02})
        else $error("exception reply body wrong");
    AST_TWO_STATUS: assert property (normHead ##1 (rspValid && rspReady && rspByte == 8'h02) |=> !rspLast)
        else $error("two status bytes expected");
    AST_ONE_STATUS: assert property (normHead ##1 (rspValid && rspReady && rspByte == 8'h01) |=> rspLast)
        else $error("one status byte expected");
    AST_CLI_FUNC: assert property (cliValid && headCli_q |=> lastResponseFunction == $past(cliByte))
        else $error("response function not recorded");
    AST_CLI_EXC: assert property (cliValid && headCli_q && cliByte[7] && !cliLast ##1 cliValid
        |=> lastExceptionCode == $past(cliByte))
        else $error("exception code not recorded");
    AST_ARR_STEP: assert property (arrWrite ##1 arrWrite |-> arrIndex == $past(arrIndex) + 8'h01)
        else $error("array index did not step by one");
endmodule : modbus_bit_read_responder_sva
bind modbus_bit_read_responder modbus_bit_read_responder_sva chk (.clk_sys, .reset, .reqValid, .reqLast,
    .reqReady, .rspValid, .rspByte, .rspLast, .rspReady, .cliValid, .cliByte, .cliLast, .lastResponseFunction,
    .lastExceptionCode, .arrWrite, .arrIndex);

//--- bench/modbus_master_model.sv
// Purpose: requesting peer that sends read PDUs and collects replies
// Assumes: bench calls send from a clock edge
// Notes: stall makes the reply consumer ready only on every other cycle, so each byte waits a cycle
`timescale 1ns/10ps
module modbus_master_model (
    // clock
    input wire logic clk_sys,
    // request stream
    output logic reqValid,
    output logic [7:0] reqByte,
    output logic reqLast,
    input wire logic reqReady,
    // reply stream
    input wire logic rspValid,
    input wire logic [7:0] rspByte,
    input wire logic rspLast,
    output logic rspReady
);
    logic [7:0] got[$];
    logic stall = 1'b0;
    initial begin
        reqValid = 1'b0;
        reqByte = 8'h00;
        reqLast = 1'b0;
        rspReady = 1'b0;
    end
    // bytes held until taken; released data shows the inverse so stale values cannot pass
    task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
        logic [7:0] b[5];
        int n;
        b = '{f, a[15:8], a[7:0], q[15:8], q[7:0]};
        got.delete();
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            reqValid <= 1'b1;
            reqByte <= b[i];
            reqLast <= (i == 4);
            do @(negedge clk_sys); while (!reqReady);
            @(posedge clk_sys);
        end
        reqValid <= 1'b0;
        reqLast <= 1'b0;
        reqByte <= ~b[4];
        rspReady <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(negedge clk_sys);
            if (rspValid && rspReady) got.push_back(rspByte);
            if (rspValid && rspReady && rspLast) break;
            @(posedge clk_sys);
            rspReady <= stall ? ~rspReady : 1'b1;
        end
        @(posedge clk_sys);
        rspReady <= 1'b0;
    endtask : send
endmodule : modbus_master_model

//--- bench/modbus_bit_read_responder_tb.sv
// Purpose: self-checking bench of the bit-read responder
// Assumes: master model drives the request side
// Notes: expected replies come from bank values and request fields
`timescale 1ns/10ps
module modbus_bit_read_responder_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [15:0] digitalOutputs = 16'h0000;
    logic [15:0] digitalInputs = 16'hFFFF;
    logic cliValid = 1'b0;
    logic [7:0] cliByte = 8'h00;
    logic cliLast = 1'b0;
    logic reqValid, reqLast, reqReady, rspValid, rspLast, rspReady, arrWrite;
    logic [7:0] reqByte, rspByte, lastResponseFunction, lastExceptionCode, arrIndex, arrData;
    logic [7:0] ai[$];
    logic [7:0] ad[$];
    int failures = 0;
    int num_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    modbus_bit_read_responder uut (.clk_sys, .reset, .digitalOutputs, .digitalInputs, .reqValid, .reqByte,
        .reqLast, .reqReady, .rspValid, .rspByte, .rspLast, .rspReady, .cliValid, .cliByte, .cliLast,
        .lastResponseFunction, .lastExceptionCode, .arrWrite, .arrIndex, .arrData);
    modbus_master_model master (.clk_sys, .reqValid, .reqByte, .reqLast, .reqReady, .rspValid, .rspByte,
        .rspLast, .rspReady);
    // array writes are logged at the edge after they appear
    always @(posedge clk_sys) if (arrWrite === 1'b1) begin
        ai.push_back(arrIndex);
        ad.push_back(arrData);
    end
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check8
    // one request; expectation formed after the send so bank updates have landed
    task automatic run(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
        logic [15:0] b;
        logic [16:0] w;
        logic [7:0] e[$];
        master.send(f, a, q);
        w = (17'h00001 << q) - 17'h00001;
        b = ((f == 8'h01) ? digitalOutputs : ~digitalInputs) >> a;
        b = b & w[15:0];
        if (f != 8'h01 && f != 8'h02) e = '{f | 8'h80, 8'h01};
        else if (a > 16'h000F || q == 16'h0000 || q > 16'h0010 || a + q > 16'h0010) e = '{f | 8'h80, 8'h02};
        else begin
            e = '{f, (q > 16'h0008) ? 8'h02 : 8'h01, b[7:0]};
            if (q > 16'h0008) e.push_back(b[15:8]);
        end
        check8("reply length", 8'(e.size()), 8'(master.got.size()));
        foreach (e[i]) check8("reply byte", e[i], master.got[i]);
    endtask : run
    task automatic t_coils;
        @(posedge clk_sys) digitalOutputs <= 16'h3334;
        run(8'h01, 16'h0002, 16'h000C);
        run(8'h01, 16'h0000, 16'h0010);
        run(8'h01, 16'h000F, 16'h0001);
        run(8'h01, 16'h0003, 16'h0009);
        $display("coils test done");
    endtask : t_coils
    task automatic t_inputs;
        @(posedge clk_sys) digitalInputs <= ~16'h3334;
        run(8'h02, 16'h0002, 16'h000C);
        master.stall = 1'b1;
        run(8'h02, 16'h0000, 16'h0010);
        run(8'h02, 16'h0007, 16'h0008);
        master.stall = 1'b0;
        $display("inputs test done");
    endtask : t_inputs
    task automatic t_errors;
        run(8'h03, 16'h0000, 16'h0001);
        run(8'h01, 16'h0010, 16'h0001);
        run(8'h02, 16'h0100, 16'h0001);
        run(8'h01, 16'h0000, 16'h0000);
        run(8'h02, 16'h0000, 16'h0011);
        run(8'h01, 16'h000A, 16'h0007);
        $display("errors test done");
    endtask : t_errors
    task automatic frame(input logic [7:0] b[]);
        ai.delete();
        ad.delete();
        @(posedge clk_sys);
        foreach (b[i]) begin
            cliValid <= 1'b1;
            cliByte <= b[i];
            cliLast <= (i == b.size() - 1);
            @(posedge clk_sys);
        end
        cliValid <= 1'b0;
        cliLast <= 1'b0;
        cliByte <= ~b[b.size() - 1];
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : frame
    task automatic t_client;
        frame('{8'h01, 8'h02, 8'hCD, 8'h0C});
        check8("response function", 8'h01, lastResponseFunction);
        check8("writes", 8'h02, 8'(ai.size()));
        check8("element 0", 8'hCD, ad[0]);
        check8("element 1", 8'h0C, ad[1]);
        check8("index 1", 8'h01, ai[1]);
        frame('{8'h82, 8'h02});
        check8("exception function", 8'h82, lastResponseFunction);
        check8("exception code", 8'h02, lastExceptionCode);
        frame('{8'h02, 8'h01, 8'h5A});
        check8("kept code", 8'h02, lastExceptionCode);
        check8("index restart", 8'h00, ai[0]);
        check8("element data", 8'h5A, ad[0]);
        $display("client test done");
    endtask : t_client
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // hang guard set well past the few hundred cycles the tests need
    initial begin
        #125000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        t_coils();
        t_inputs();
        t_errors();
        t_client();
        report_and_stop();
    end
endmodule : modbus_bit_read_responder_tb
